/* File: design/tsps_regs.svh */
// Constants for the test strap decoder and pin state controller
`ifndef TSPS_REGS_SVH
`define TSPS_REGS_SVH
`define TSPS_PCI_CLK_MHZ      33
`define TSPS_CNT_W            5
`define TSPS_CNT_NAND1        5'h04
`define TSPS_CNT_NAND4        5'h07
`define TSPS_CNT_ALLZ         5'h08
`define TSPS_CNT_RSV_LO       5'h0A
`define TSPS_CNT_RSV_HI       5'h18
`define TSPS_CNT_MAX          5'h19
`endif

/* File: design/tsps_pkg.sv */
// Types for the test strap decoder and pin state controller
package tsps_pkg;
    // Test mode selected by the strap
    typedef enum logic [2:0] {
        TSPS_MODE_NONE,
        TSPS_MODE_NAND1,
        TSPS_MODE_NAND2,
        TSPS_MODE_NAND3,
        TSPS_MODE_NAND4,
        TSPS_MODE_ALLZ
    } tsps_mode_t;
    // Pin control phase; S4 and S5 share one entry
    typedef enum logic [2:0] {
        TSPS_PH_RESET,
        TSPS_PH_AFTER,
        TSPS_PH_S1,
        TSPS_PH_S3,
        TSPS_PH_S45,
        TSPS_PH_G3
    } tsps_phase_t;
endpackage

/* File: design/tsps_top.sv */
// Test strap decoder and per power state output pin controller
`timescale 1ns/1ns
`include "tsps_regs.svh"

////////////////////////////////////////////////////////////////////////////
module tsps_top
    import tsps_pkg::*;
#(
    parameter int CNT_W = `TSPS_CNT_W
) (
    // Clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    // Strap and power inputs
    input  wire logic              power_good_in,
    input  wire logic              rtc_well_reset_n,
    input  wire tsps_phase_t       phase_in,
    // Selected test mode
    output tsps_mode_t             test_mode,
    // PCI bus
    output logic [31:0]            pci_ad_o,
    output logic [31:0]            pci_ad_oe,
    output logic [3:0]             pci_cbe_n_o,
    output logic [3:0]             pci_cbe_n_oe,
    output logic                   pci_par_o,
    output logic                   pci_par_oe,
    output logic                   pci_gnt_n_o,
    output logic                   pci_gnt_n_oe,
    output logic                   pci_bus_reset_out_n,
    output logic                   pci_bus_reset_out_oe,
    // LPC
    output logic [3:0]             lpc_ad_o,
    output logic                   lpc_ad_oe,
    output logic                   lpc_frame_n_o,
    output logic                   lpc_frame_n_oe,
    // IDE
    output logic [2:0]             primary_drive_addr,
    output logic                   primary_drive_addr_oe,
    output logic                   primary_chip_select_a_n,
    output logic                   primary_read_strobe_n,
    output logic                   primary_dma_ack_n,
    output logic                   ide_ctl_oe,
    output logic [15:0]            primary_drive_data,
    output logic                   primary_drive_data_oe,
    // Interrupts and USB, enables only
    output logic                   pci_irq_lines_n_oe,
    output logic                   serirq_oe,
    output logic                   apic_serial_data_oe,
    output logic                   usb_port0_plus_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Strap counter and decode
    logic [CNT_W-1:0] cnt_reg;
    logic             rtc_low_q_reg;
    tsps_mode_t       mode_reg;
    logic             locked_reg;
    logic [CNT_W-1:0] cnt_next;
    tsps_mode_t       dec_mode;
    wire              strap_active = power_good_in && !locked_reg;
    wire              rtc_rise     = rtc_low_q_reg && rtc_well_reset_n;

    // Saturate so long holds read as more than 24
    assign cnt_next = (cnt_reg == CNT_W'(`TSPS_CNT_MAX)) ? cnt_reg
                    : cnt_reg + CNT_W'(1);

    // Decode of the finished count
    always_comb begin
        if (cnt_reg >= CNT_W'(`TSPS_CNT_NAND1) &&
            cnt_reg <= CNT_W'(`TSPS_CNT_NAND4)) begin
            dec_mode = tsps_mode_t'(3'(cnt_reg - CNT_W'(3)));
        end else if (cnt_reg == CNT_W'(`TSPS_CNT_ALLZ)) begin
            dec_mode = TSPS_MODE_ALLZ;
        end else begin
            dec_mode = TSPS_MODE_NONE;
        end
    end

    // Counting ends at the first release; later pulses are ignored.
    // Power loss clears only on enabled edges so a low enable freezes all.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || (clk_en && !power_good_in)) begin
            cnt_reg       <= '0;
            rtc_low_q_reg <= 1'b0;
            mode_reg      <= TSPS_MODE_NONE;
            locked_reg    <= 1'b0;
        end else if (clk_en && strap_active) begin
            rtc_low_q_reg <= !rtc_well_reset_n;
            if (!rtc_well_reset_n) begin
                cnt_reg <= cnt_next;
            end
            if (rtc_rise) begin
                mode_reg   <= dec_mode;
                locked_reg <= 1'b1;
            end
        end
    end
    assign test_mode = mode_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pin state decode per phase
    wire core_on = (phase_in == TSPS_PH_RESET) || (phase_in == TSPS_PH_AFTER)
                || (phase_in == TSPS_PH_S1);
    wire in_rst  = (phase_in == TSPS_PH_RESET);
    wire res_on  = (phase_in != TSPS_PH_G3);
    wire all_z   = (mode_reg == TSPS_MODE_ALLZ);
    wire drv     = core_on && !all_z;

    // Registered outputs so each pin leaves a flip-flop
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pci_ad_o <= '0; pci_ad_oe <= '0;
            pci_cbe_n_o <= '1; pci_cbe_n_oe <= '0;
            pci_par_o <= 1'b0; pci_par_oe <= 1'b0;
            pci_gnt_n_o <= 1'b1; pci_gnt_n_oe <= 1'b0;
            pci_bus_reset_out_n <= 1'b0; pci_bus_reset_out_oe <= 1'b0;
            lpc_ad_o <= '1; lpc_ad_oe <= 1'b0;
            lpc_frame_n_o <= 1'b1; lpc_frame_n_oe <= 1'b0;
            primary_drive_addr <= '0; primary_drive_addr_oe <= 1'b0;
            primary_chip_select_a_n <= 1'b1;
            primary_read_strobe_n <= 1'b1;
            primary_dma_ack_n <= 1'b1;
            ide_ctl_oe <= 1'b0;
            primary_drive_data <= '0; primary_drive_data_oe <= 1'b0;
            pci_irq_lines_n_oe <= 1'b0;
            serirq_oe <= 1'b0;
            apic_serial_data_oe <= 1'b0;
            usb_port0_plus_oe <= 1'b0;
        end else if (clk_en) begin
            pci_ad_o     <= '0;
            pci_ad_oe    <= {32{drv && !in_rst}};
            pci_cbe_n_o  <= '1;
            pci_cbe_n_oe <= {4{drv && !in_rst}};
            pci_par_o    <= 1'b0;
            pci_par_oe   <= drv && !in_rst;
            pci_gnt_n_o  <= 1'b1;
            pci_gnt_n_oe <= drv;
            // Resume plane: driven in every state but G3, and not at all in all-Z mode
            pci_bus_reset_out_n  <= !in_rst && core_on;
            pci_bus_reset_out_oe <= res_on && !all_z;
            lpc_ad_o       <= '1;
            lpc_ad_oe      <= drv;
            lpc_frame_n_o  <= 1'b1;
            lpc_frame_n_oe <= drv;
            // Undefined after reset: driven, held low here
            primary_drive_addr      <= '0;
            primary_drive_addr_oe   <= drv;
            primary_chip_select_a_n <= 1'b1;
            primary_read_strobe_n   <= 1'b1;
            primary_dma_ack_n       <= 1'b1;
            ide_ctl_oe              <= drv;
            primary_drive_data      <= '0;
            primary_drive_data_oe   <= 1'b0;
            pci_irq_lines_n_oe  <= 1'b0;
            serirq_oe           <= 1'b0;
            apic_serial_data_oe <= 1'b0;
            usb_port0_plus_oe   <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_mode_held: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        locked_reg && power_good_in && $past(power_good_in) && clk_en
        |=> $stable(mode_reg))
        else $error("test mode changed while latched");
    a_mode_clear: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && !power_good_in |=> mode_reg == TSPS_MODE_NONE)
        else $error("test mode kept after power good fell");
    a_nand_decode: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && strap_active && rtc_rise && cnt_reg == 5'h04
        |=> mode_reg == TSPS_MODE_NAND1)
        else $error("count four did not select first chain");
    a_allz_decode: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && strap_active && rtc_rise && cnt_reg == 5'h08
        |=> mode_reg == TSPS_MODE_ALLZ)
        else $error("count eight did not select all-Z");
    // All-Z must silence the resume plane pin as well as the core pins
    a_allz_quiet: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && all_z |=> !pci_bus_reset_out_oe && !lpc_ad_oe
        && !ide_ctl_oe && pci_ad_oe == '0)
        else $error("pin driven in all-Z mode");
    a_count_up: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && strap_active && !rtc_well_reset_n && cnt_reg < 5'h19
        && power_good_in ##1 power_good_in
        |-> cnt_reg == $past(cnt_reg) + 5'h01)
        else $error("low-time count did not advance");
    // A wrap would turn a long hold back into a valid chain count
    a_count_sat: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && strap_active && !rtc_well_reset_n
        && cnt_reg == CNT_W'(`TSPS_CNT_MAX)
        |=> cnt_reg == CNT_W'(`TSPS_CNT_MAX))
        else $error("long strap count wrapped");
    a_core_off: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && !core_on |=> !lpc_ad_oe && !pci_gnt_n_oe && !ide_ctl_oe)
        else $error("core output driven with plane off");
    a_resume_on: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && phase_in == TSPS_PH_S3 && !all_z
        |=> pci_bus_reset_out_oe && !pci_bus_reset_out_n)
        else $error("bus reset out not driven low in S3");
    a_rst_out_low: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && in_rst |=> !pci_bus_reset_out_n)
        else $error("bus reset out high during reset");
    a_cbe_float: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && in_rst |=> pci_cbe_n_oe == 4'h0 && pci_ad_oe == '0)
        else $error("byte enables driven during reset");
    a_irq_usb_z: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ##1 !pci_irq_lines_n_oe && !serirq_oe && !usb_port0_plus_oe
        && !apic_serial_data_oe && !primary_drive_data_oe)
        else $error("floating pin driven");
endmodule

/* File: tb/tsps_strap_model.sv */
// Board-side model driving power good and the RTC-well strap
`timescale 1ns/1ns
module tsps_strap_model (
    // Clock and bus reset as the board sees them
    input  wire logic clk_sys,
    input  wire logic pci_bus_reset_out_n,
    // Strap pins
    output logic      power_good_in,
    output logic      rtc_well_reset_n
);
    // Idle: power off, strap released high
    initial begin
        power_good_in = 1'b0;
        rtc_well_reset_n = 1'b1;
    end
    // Raise power good and hold the strap low for n clocks
    task automatic strap(input int n);
        int w;
        w = 0;
        while (pci_bus_reset_out_n !== 1'b1 && w < 20) begin
            @(posedge clk_sys);
            w++;
        end
        // Reserved lengths are never sent; stretch past them
        if (n >= 10 && n <= 24) n = 25;
        @(posedge clk_sys) #1;
        power_good_in = 1'b1;
        // A zero length strap never pulls the pin low, so no glitch
        rtc_well_reset_n = (n == 0);
        if (n > 0) begin
            repeat (n) @(posedge clk_sys);
            #1 rtc_well_reset_n = 1'b1;
        end
    endtask
    // Drop power good so a later strap starts afresh
    task automatic drop();
        @(posedge clk_sys) #1;
        power_good_in = 1'b0;
        @(posedge clk_sys) #1;
    endtask
endmodule

/* File: tb/tsps_top_tb.sv */
// Self-checking bench for the strap decoder and pin controller
`timescale 1ns/1ns
module tsps_top_tb;
    import tsps_pkg::*;
    logic clk_sys = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
    tsps_phase_t phase_in = TSPS_PH_RESET;
    logic power_good_in, rtc_well_reset_n;
    tsps_mode_t test_mode;
    logic [31:0] pci_ad_o, pci_ad_oe;
    logic [15:0] primary_drive_data;
    logic [3:0]  pci_cbe_n_o, pci_cbe_n_oe, lpc_ad_o;
    logic [2:0]  primary_drive_addr;
    logic pci_par_o, pci_par_oe, pci_gnt_n_o, pci_gnt_n_oe;
    logic pci_bus_reset_out_n, pci_bus_reset_out_oe, lpc_ad_oe;
    logic lpc_frame_n_o, lpc_frame_n_oe, primary_drive_addr_oe;
    logic primary_chip_select_a_n, primary_read_strobe_n;
    logic primary_dma_ack_n, ide_ctl_oe, primary_drive_data_oe;
    logic pci_irq_lines_n_oe, serirq_oe, apic_serial_data_oe;
    logic usb_port0_plus_oe;
    int n_errors = 0, checks = 0, cyc = 0;
    // All enables and every driven level but primary_drive_data packed for table compares
    wire [47:0] oe_v = {pci_ad_oe, pci_cbe_n_oe, pci_par_oe, pci_gnt_n_oe,
        pci_bus_reset_out_oe, lpc_ad_oe, lpc_frame_n_oe,
        primary_drive_addr_oe, ide_ctl_oe, primary_drive_data_oe,
        pci_irq_lines_n_oe, serirq_oe, apic_serial_data_oe,
        usb_port0_plus_oe};
    wire [49:0] val_v = {pci_ad_o, pci_cbe_n_o, pci_par_o, pci_gnt_n_o,
        pci_bus_reset_out_n, lpc_ad_o, lpc_frame_n_o, primary_drive_addr,
        primary_chip_select_a_n, primary_read_strobe_n, primary_dma_ack_n};
    tsps_top DUT (.clk_sys, .sys_rst, .clk_en, .power_good_in,
        .rtc_well_reset_n, .phase_in, .test_mode, .pci_ad_o, .pci_ad_oe,
        .pci_cbe_n_o, .pci_cbe_n_oe, .pci_par_o, .pci_par_oe, .pci_gnt_n_o,
        .pci_gnt_n_oe, .pci_bus_reset_out_n, .pci_bus_reset_out_oe,
        .lpc_ad_o, .lpc_ad_oe, .lpc_frame_n_o, .lpc_frame_n_oe,
        .primary_drive_addr, .primary_drive_addr_oe,
        .primary_chip_select_a_n, .primary_read_strobe_n,
        .primary_dma_ack_n, .ide_ctl_oe, .primary_drive_data,
        .primary_drive_data_oe, .pci_irq_lines_n_oe, .serirq_oe,
        .apic_serial_data_oe, .usb_port0_plus_oe);
    tsps_strap_model M (.clk_sys, .pci_bus_reset_out_n, .power_good_in,
        .rtc_well_reset_n);
    // 250 MHz clock and a cycle ceiling against hangs
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic cmp_pins(input logic [63:0] a, input logic [63:0] e);
        checks++;
        if (a !== e) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic cmp_mode(input tsps_mode_t a, input tsps_mode_t e);
        checks++;
        if (a !== e) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    // Walk every phase; values only checked where they are driven
    task automatic t_pins();
        logic [47:0] ox[6] = '{48'h07E0, 48'hFFFF_FFFF_FFE0,
            48'hFFFF_FFFF_FFE0, 48'h0200, 48'h0200, 48'h0};
        logic [49:0] vm[6] = '{50'h1FFF, 50'h3_FFFF_FFFF_FFFF,
            50'h3_FFFF_FFFF_FFFF, 50'h0800, 50'h0800, 50'h0};
        logic [49:0] vx[6] = '{50'h17C7, 50'h3_DFC7, 50'h3_DFC7,
            50'h0, 50'h0, 50'h0};
        for (int i = 0; i < 6; i++) begin
            phase_in = tsps_phase_t'(i);
            tick(2);
            cmp_pins(64'(oe_v), 64'(ox[i]));
            cmp_pins(64'(val_v & vm[i]), 64'(vx[i]));
            cmp_pins(64'(primary_drive_data), 64'h0);
        end
        // A held clock enable freezes the pins
        clk_en = 1'b0;
        phase_in = TSPS_PH_S1;
        tick(3);
        cmp_pins(64'(oe_v), 64'h0);
        clk_en = 1'b1;
        $display("pin phase test done");
    endtask
    // Every strap length of the decode table
    task automatic t_modes();
        int nl[10] = '{0, 3, 4, 5, 6, 7, 8, 9, 25, 30};
        tsps_mode_t ml[10] = '{TSPS_MODE_NONE, TSPS_MODE_NONE,
            TSPS_MODE_NAND1, TSPS_MODE_NAND2, TSPS_MODE_NAND3,
            TSPS_MODE_NAND4, TSPS_MODE_ALLZ, TSPS_MODE_NONE,
            TSPS_MODE_NONE, TSPS_MODE_NONE};
        for (int i = 0; i < 10; i++) begin
            M.strap(nl[i]);
            tick(3);
            cmp_mode(test_mode, ml[i]);
            if (ml[i] == TSPS_MODE_ALLZ)
                cmp_pins(64'(oe_v), 64'h0);
            M.drop();
        end
        $display("strap decode test done");
    endtask
    // Mode holds through a second pulse and clears with power good
    task automatic t_latch();
        M.strap(4);
        tick(3);
        cmp_mode(test_mode, TSPS_MODE_NAND1);
        M.strap(6);
        tick(3);
        cmp_mode(test_mode, TSPS_MODE_NAND1);
        M.drop();
        cmp_mode(test_mode, TSPS_MODE_NONE);
        // Reset in mid-run clears a latched mode and every enable
        M.strap(5);
        tick(3);
        cmp_mode(test_mode, TSPS_MODE_NAND2);
        sys_rst = 1'b1;
        tick(1);
        sys_rst = 1'b0;
        cmp_mode(test_mode, TSPS_MODE_NONE);
        cmp_pins(64'(oe_v), 64'h0);
        M.drop();
        $display("strap latch test done");
    endtask
    task automatic close_out();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Reset for six cycles, then run the scenarios
    initial begin
        tick(6);
        cmp_pins(64'(oe_v), 64'h0);
        sys_rst = 1'b0;
        tick(1);
        t_pins();
        phase_in = TSPS_PH_AFTER;
        tick(2);
        t_modes();
        t_latch();
        close_out();
    end
endmodule
